// ==== verilog/sgc_defs.vh ====
// Constants for the switch global forwarding control register pair.
// Definitions only; included by the register bank and its size checker.
`ifndef SGC_DEFS_VH
`define SGC_DEFS_VH

// ==========================================================
// Register indices and byte addresses (byte address = 4 * index)
`define SGC_IDX_CTRL_B 8'h04
`define SGC_IDX_CTRL_C 8'h05
`define SGC_ADDR_W 8
`define SGC_ADDR_CTRL_B 8'h10
`define SGC_ADDR_CTRL_C 8'h14

// ==========================================================
// Control B field positions
`define SGC_B_VLAN_MISMATCH_DISCARD 7
`define SGC_B_MCAST_STORM_DIS 6
`define SGC_B_BP_CARRIER_MODE 5
`define SGC_B_FAIR_MODE 4
`define SGC_B_NO_COLL_DROP 3
`define SGC_B_HUGE_FRAME 2
`define SGC_B_LEGAL_MAX_DIS 1
`define SGC_B_PRIO_BUF_RESERVE 0

// ==========================================================
// Control C field positions; only bits 7:6 live here, the rest read zero
`define SGC_C_VLAN_ENABLE 7
`define SGC_C_IGMP_SNOOP 6
`define SGC_C_IMPL_MASK 8'hC0

// ==========================================================
// Reset values, strap bits are merged in at reset
`define SGC_B_RESET_FIXED 8'hF0
`define SGC_C_RESET 8'h00

// ==========================================================
// Frame limits in bytes and related figures
`define SGC_LEN_W 11
`define SGC_LEN_HUGE 11'h77C
`define SGC_LEN_RELAXED 11'h600
`define SGC_LEN_TAGGED 11'h5F2
`define SGC_LEN_UNTAGGED 11'h5EE
`define SGC_COLL_W 5
`define SGC_COLL_LIMIT 5'h10
`define SGC_HP_RESERVE 6'h30
`define SGC_HP_NONE 6'h00

`endif

// ==== verilog/sgc_size_limit.v ====
// Frame size limit selection and length check for the forwarding control bank.
// Assumes length, tag and special-tag qualifiers are stable while checked.
`timescale 1ns/10ps
`include "sgc_defs.vh"

module sgc_size_limit #(
	parameter LEN_W = `SGC_LEN_W
) (
	// Settings
	input wire i_huge,
	input wire i_legal_dis,
	// Frame attributes
	input wire [LEN_W-1:0] i_len,
	input wire i_tagged,
	input wire i_special_cpu_to_port,
	// Result
	output reg [LEN_W-1:0] o_limit,
	output wire o_too_long
);

	// ==========================================================
	// Limit selection
	always @* begin
		if (i_huge) begin
			o_limit = `SGC_LEN_HUGE; // R6 R7
		end else if (i_legal_dis) begin
			o_limit = `SGC_LEN_RELAXED; // R7 R8
		end else if (i_tagged && !i_special_cpu_to_port) begin
			o_limit = `SGC_LEN_TAGGED; // R9
		end else if (i_tagged) begin
			// Special-tagged CPU frames carry an extra tag, so use the relaxed limit
			o_limit = `SGC_LEN_RELAXED; // R9
		end else begin
			o_limit = `SGC_LEN_UNTAGGED; // R9
		end
	end

	// Limits are inclusive
	assign o_too_long = (i_len > o_limit);

endmodule // sgc_size_limit

// ==== verilog/sgc_forward_ctrl.v ====
// Global forwarding control register pair with its frame policy decisions.
// Assumes an Avalon-MM master on the 40 MHz core clock and synchronous reset;
// frame attributes arrive synchronous and are judged one cycle after i_frm_valid.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/10ps
`include "sgc_defs.vh"

// Behaviour
// R1: Mismatch discard set blocks all port-VLAN crossings, clear lets only known unicast cross.
// R2: Back pressure mode 1 picks carrier-sense based and 0 collision based back pressure.
// R3: Fair mode set drops frames of a non-flow-controlled port sharing a congested destination.
// R4: Fair mode clear throttles the flow-controlled source sharing a congested destination.
// R5: Collision bit set keeps frames after 16 or more collisions, clear drops them.
// R6: With huge frames on, frames up to and including 1916 bytes are accepted.
// R7: The huge frame bit overrides the legal-maximum bit, which alone decides when huge is off.
// R8: Legal-maximum check disabled with huge off accepts frames up to and including 1536 bytes.
// R9: Both size bits clear cap tagged at 1522 and untagged at 1518, CPU special tags exempt.
// R10: Buffer reserve set holds 48 buffers per output queue for high priority, else none.
// R11: VLAN enable set selects tag-based VLAN mode, which needs the VLAN table loaded first.
// R12: With IGMP snoop set every IGMP frame is also forwarded to the switch MII port.
// R13: Reset loads the two strap bits from their pins, the top four bits as ones, the rest zero.
module sgc_forward_ctrl (
	// Clock and reset
	input wire i_clk,
	input wire i_rst,
	// Straps
	input wire i_collision_drop_strap_pin,
	input wire i_max_size_strap_pin,
	// Avalon-MM slave
	input wire [`SGC_ADDR_W-1:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	output reg [31:0] o_avs_readdata,
	output reg o_avs_waitrequest,
	// Frame judgement request
	input wire i_frm_valid,
	input wire [`SGC_LEN_W-1:0] i_frm_len,
	input wire i_frm_tagged,
	input wire i_frm_special_tag,
	input wire i_frm_dest_port14,
	input wire [`SGC_COLL_W-1:0] i_frm_coll_cnt,
	input wire i_frm_known_unicast,
	input wire i_frm_crosses_vlan,
	input wire i_frm_is_igmp,
	input wire i_frm_dest_congested,
	input wire i_frm_src_has_fc,
	input wire i_frm_peer_other_fc,
	// Frame judgement answer
	output reg o_frm_done,
	output reg o_frm_drop_size,
	output reg o_frm_drop_coll,
	output reg o_frm_drop_vlan,
	output reg o_frm_drop_fair,
	output reg o_frm_throttle_src,
	output reg o_frm_copy_to_mii,
	// Static settings toward the datapath
	output reg o_bp_carrier_mode,
	output reg o_mcast_storm_excl,
	output reg [5:0] o_hp_reserve_bufs,
	output reg o_tag_vlan_mode,
	output reg o_igmp_snoop,
	output reg [`SGC_LEN_W-1:0] o_max_len_untagged
);

	// ==========================================================
	// Register storage
	reg [7:0] ctrl_b_reg;
	reg [7:0] ctrl_b_next;
	reg [7:0] ctrl_c_reg;
	reg [7:0] ctrl_c_next;
	reg [31:0] rdata_next;
	reg wait_next;

	wire bus_req;
	wire hit_b;
	wire hit_c;
	wire commit;

	assign bus_req = i_avs_read | i_avs_write;
	assign hit_b = (i_avs_address == `SGC_ADDR_CTRL_B);
	assign hit_c = (i_avs_address == `SGC_ADDR_CTRL_C);
	// Write lands at the edge where the master sees waitrequest low
	assign commit = i_avs_write & ~o_avs_waitrequest;

	// ==========================================================
	// Bus handshake: one wait cycle, then a single low cycle
	always @* begin
		wait_next = 1'b1;
		rdata_next = o_avs_readdata;
		if (bus_req && o_avs_waitrequest) begin
			wait_next = 1'b0;
			rdata_next = 32'h0000_0000;
			if (hit_b) begin
				rdata_next = {24'h00_0000, ctrl_b_reg};
			end else if (hit_c) begin
				rdata_next = {24'h00_0000, ctrl_c_reg & `SGC_C_IMPL_MASK};
			end
		end
	end

	always @* begin
		ctrl_b_next = ctrl_b_reg;
		ctrl_c_next = ctrl_c_reg;
		if (commit && i_avs_byteenable[0]) begin
			if (hit_b) begin
				ctrl_b_next = i_avs_writedata[7:0];
			end
			if (hit_c) begin
				// Unimplemented bits of C are kept at zero
				ctrl_c_next = i_avs_writedata[7:0] & `SGC_C_IMPL_MASK;
			end
		end
	end

	always @(posedge i_clk) begin
		if (i_rst) begin
			// Straps are sampled throughout reset; the last value wins
			ctrl_b_reg <= `SGC_B_RESET_FIXED; // R13
			ctrl_b_reg[`SGC_B_NO_COLL_DROP] <= i_collision_drop_strap_pin; // R13
			ctrl_b_reg[`SGC_B_LEGAL_MAX_DIS] <= i_max_size_strap_pin; // R13
			ctrl_c_reg <= `SGC_C_RESET; // R13
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= 32'h0000_0000;
		end else begin
			ctrl_b_reg <= ctrl_b_next;
			ctrl_c_reg <= ctrl_c_next;
			o_avs_waitrequest <= wait_next;
			o_avs_readdata <= rdata_next;
		end
	end

	// ==========================================================
	// Field aliases
	wire vlan_discard_all;
	wire mcast_storm_dis;
	wire bp_carrier;
	wire fair_mode;
	wire no_coll_drop;
	wire huge_on;
	wire legal_dis;
	wire prio_reserve;
	wire vlan_en;
	wire igmp_en;

	assign vlan_discard_all = ctrl_b_reg[`SGC_B_VLAN_MISMATCH_DISCARD];
	assign mcast_storm_dis = ctrl_b_reg[`SGC_B_MCAST_STORM_DIS];
	assign bp_carrier = ctrl_b_reg[`SGC_B_BP_CARRIER_MODE];
	assign fair_mode = ctrl_b_reg[`SGC_B_FAIR_MODE];
	assign no_coll_drop = ctrl_b_reg[`SGC_B_NO_COLL_DROP];
	assign huge_on = ctrl_b_reg[`SGC_B_HUGE_FRAME];
	assign legal_dis = ctrl_b_reg[`SGC_B_LEGAL_MAX_DIS];
	assign prio_reserve = ctrl_b_reg[`SGC_B_PRIO_BUF_RESERVE];
	assign vlan_en = ctrl_c_reg[`SGC_C_VLAN_ENABLE];
	assign igmp_en = ctrl_c_reg[`SGC_C_IGMP_SNOOP];

	// ==========================================================
	// Size checks: one for the frame, one for the untagged limit report
	wire size_too_long;
	wire [`SGC_LEN_W-1:0] frame_limit;
	wire [`SGC_LEN_W-1:0] untagged_limit;

	sgc_size_limit #(
		.LEN_W(`SGC_LEN_W)
	) u_frame_check (
		.i_huge(huge_on),
		.i_legal_dis(legal_dis),
		.i_len(i_frm_len),
		.i_tagged(i_frm_tagged),
		.i_special_cpu_to_port(i_frm_special_tag & i_frm_dest_port14),
		.o_limit(frame_limit),
		.o_too_long(size_too_long)
	);

	sgc_size_limit #(
		.LEN_W(`SGC_LEN_W)
	) u_untagged_limit (
		.i_huge(huge_on),
		.i_legal_dis(legal_dis),
		.i_len({`SGC_LEN_W{1'b0}}),
		.i_tagged(1'b0),
		.i_special_cpu_to_port(1'b0),
		.o_limit(untagged_limit),
		.o_too_long()
	);

	// ==========================================================
	// Frame decisions
	reg drop_vlan_next;
	reg drop_coll_next;
	reg drop_fair_next;
	reg throttle_next;
	reg shared_dest;

	always @* begin
		// Crossing is judged only when the lookup says it crosses
		drop_vlan_next = 1'b0;
		if (i_frm_crosses_vlan) begin
			drop_vlan_next = vlan_discard_all | ~i_frm_known_unicast; // R1
		end
		drop_coll_next = ~no_coll_drop & (i_frm_coll_cnt >= `SGC_COLL_LIMIT); // R5
		// Conflict only when one side uses flow control and the other does not
		shared_dest = i_frm_dest_congested & (i_frm_src_has_fc ^ i_frm_peer_other_fc);
		drop_fair_next = 1'b0;
		throttle_next = 1'b0;
		if (shared_dest) begin
			if (fair_mode) begin
				drop_fair_next = ~i_frm_src_has_fc; // R3
			end else begin
				throttle_next = i_frm_src_has_fc; // R4
			end
		end
	end

	always @(posedge i_clk) begin
		if (i_rst) begin
			o_frm_done <= 1'b0;
			o_frm_drop_size <= 1'b0;
			o_frm_drop_coll <= 1'b0;
			o_frm_drop_vlan <= 1'b0;
			o_frm_drop_fair <= 1'b0;
			o_frm_throttle_src <= 1'b0;
			o_frm_copy_to_mii <= 1'b0;
		end else begin
			o_frm_done <= i_frm_valid;
			if (i_frm_valid) begin
				o_frm_drop_size <= size_too_long; // R6 R8 R9
				o_frm_drop_coll <= drop_coll_next;
				o_frm_drop_vlan <= drop_vlan_next;
				o_frm_drop_fair <= drop_fair_next;
				o_frm_throttle_src <= throttle_next;
				o_frm_copy_to_mii <= igmp_en & i_frm_is_igmp; // R12
			end
		end
	end

	// ==========================================================
	// Static settings, registered so the datapath sees clean levels
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_bp_carrier_mode <= 1'b1;
			o_mcast_storm_excl <= 1'b1;
			o_hp_reserve_bufs <= `SGC_HP_NONE;
			o_tag_vlan_mode <= 1'b0;
			o_igmp_snoop <= 1'b0;
			o_max_len_untagged <= `SGC_LEN_UNTAGGED;
		end else begin
			o_bp_carrier_mode <= bp_carrier; // R2
			o_mcast_storm_excl <= mcast_storm_dis;
			o_hp_reserve_bufs <= prio_reserve ? `SGC_HP_RESERVE : `SGC_HP_NONE; // R10
			// The VLAN table must be loaded by software before setting this
			o_tag_vlan_mode <= vlan_en; // R11
			o_igmp_snoop <= igmp_en; // R12
			o_max_len_untagged <= untagged_limit; // R7
		end
	end

endmodule // sgc_forward_ctrl

// ==== tb/sgc_forward_ctrl_properties.sv ====
// Checker of frame decision timing and bounds for the forwarding control bank.
// Assumes binding to sgc_forward_ctrl; it sees that module's ports only.
`timescale 1ns/10ps
// ==========================================
// Checker
module sgc_fwd_chk (
	input wire i_clk, input wire i_rst, input wire i_frm_valid, input wire [10:0] i_frm_len,
	input wire i_frm_crosses_vlan, input wire i_frm_known_unicast, input wire [4:0] i_frm_coll_cnt,
	input wire i_frm_is_igmp, input wire o_frm_done, input wire o_frm_drop_vlan,
	input wire o_frm_drop_coll, input wire o_frm_drop_size, input wire o_frm_copy_to_mii,
	input wire o_frm_drop_fair, input wire o_frm_throttle_src, input wire [10:0] o_max_len_untagged,
	input wire i_frm_dest_congested, input wire i_frm_src_has_fc
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	chk_done_pulse: assert property (i_frm_valid |=> o_frm_done) else $error("done late");
	chk_done_idle: assert property (!i_frm_valid |=> !o_frm_done) else $error("done stray");
	chk_vlan_unknown: assert property (i_frm_valid && i_frm_crosses_vlan && !i_frm_known_unicast
		|=> o_frm_drop_vlan) else $error("vlan drop missed");
	chk_coll_keep: assert property (i_frm_valid && i_frm_coll_cnt < 5'h10
		|=> !o_frm_drop_coll) else $error("coll drop early");
	chk_size_huge: assert property (i_frm_valid && i_frm_len > 11'h77C |=> o_frm_drop_size)
		else $error("oversize kept");
	chk_size_small: assert property (i_frm_valid && i_frm_len <= 11'h5EE |=> !o_frm_drop_size)
		else $error("small dropped");
	chk_igmp_copy: assert property (i_frm_valid && !i_frm_is_igmp |=> !o_frm_copy_to_mii)
		else $error("stray copy");
	chk_fair_excl: assert property (i_frm_valid && i_frm_src_has_fc |=> !o_frm_drop_fair)
		else $error("fair drop on fc port");
	chk_fair_quiet: assert property (i_frm_valid && !i_frm_dest_congested
		|=> !o_frm_drop_fair && !o_frm_throttle_src) else $error("fair action stray");
	chk_throttle_fc: assert property (i_frm_valid && !i_frm_src_has_fc |=> !o_frm_throttle_src)
		else $error("throttle without fc");
	chk_max_len: assert property (o_max_len_untagged inside {11'h77C, 11'h600, 11'h5EE})
		else $error("bad limit");
endmodule // sgc_fwd_chk

bind sgc_forward_ctrl sgc_fwd_chk u_sgc_fwd_chk (.i_clk(i_clk), .i_rst(i_rst),
	.i_frm_valid(i_frm_valid), .i_frm_len(i_frm_len), .i_frm_crosses_vlan(i_frm_crosses_vlan),
	.i_frm_known_unicast(i_frm_known_unicast), .i_frm_coll_cnt(i_frm_coll_cnt),
	.i_frm_is_igmp(i_frm_is_igmp), .o_frm_done(o_frm_done), .o_frm_drop_vlan(o_frm_drop_vlan),
	.o_frm_drop_coll(o_frm_drop_coll), .o_frm_drop_size(o_frm_drop_size),
	.o_frm_copy_to_mii(o_frm_copy_to_mii), .o_frm_drop_fair(o_frm_drop_fair),
	.o_frm_throttle_src(o_frm_throttle_src), .o_max_len_untagged(o_max_len_untagged),
	.i_frm_dest_congested(i_frm_dest_congested), .i_frm_src_has_fc(i_frm_src_has_fc));

// ==== tb/test_switch_global_control_regs.sv ====
// Bench for the forwarding control bank: registers, straps, frame decisions.
// Assumes a lone 40 MHz clock; the bench is the Avalon-MM master.
`timescale 1ns/10ps
// ==========================================
// Bench
module test_switch_global_control_regs;
	reg i_clk = 0, i_rst = 1, s_col = 1, s_max = 0, rd = 0, wr = 0, fv = 0;
	reg [7:0] adr = 8'h00, rb, rc;
	reg [31:0] wd = 32'h0, rnd = 32'h99E1, rdat;
	reg [3:0] be = 4'hF;
	reg [10:0] len = 11'h0;
	reg [4:0] cc = 5'h0;
	reg [8:0] fa = 9'h0; // tag special port14 known crosses igmp congested src_fc peer_fc
	wire [31:0] rdo;
	wire wrq, dn, dsz, dco, dvl, dfr, thr, mii, bp, mce, vm, ig;
	wire [5:0] hp;
	wire [10:0] ml;
	integer fail_count = 0, checks = 0, i, n;

	sgc_forward_ctrl u_sgc_forward_ctrl (.i_clk(i_clk), .i_rst(i_rst),
		.i_collision_drop_strap_pin(s_col), .i_max_size_strap_pin(s_max),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.i_avs_byteenable(be), .o_avs_readdata(rdo), .o_avs_waitrequest(wrq),
		.i_frm_valid(fv), .i_frm_len(len), .i_frm_tagged(fa[8]), .i_frm_special_tag(fa[7]),
		.i_frm_dest_port14(fa[6]), .i_frm_coll_cnt(cc), .i_frm_known_unicast(fa[5]),
		.i_frm_crosses_vlan(fa[4]), .i_frm_is_igmp(fa[3]), .i_frm_dest_congested(fa[2]),
		.i_frm_src_has_fc(fa[1]), .i_frm_peer_other_fc(fa[0]), .o_frm_done(dn),
		.o_frm_drop_size(dsz), .o_frm_drop_coll(dco), .o_frm_drop_vlan(dvl),
		.o_frm_drop_fair(dfr), .o_frm_throttle_src(thr), .o_frm_copy_to_mii(mii),
		.o_bp_carrier_mode(bp), .o_mcast_storm_excl(mce), .o_hp_reserve_bufs(hp),
		.o_tag_vlan_mode(vm), .o_igmp_snoop(ig), .o_max_len_untagged(ml));

	always #12.5 i_clk = ~i_clk;

	function [31:0] nx(input [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Decision order: size, coll, vlan, fair, throttle, copy
	function [5:0] exp_dec(input [7:0] b, input [7:0] c, input [10:0] l, input [4:0] k,
		input [8:0] a);
		reg [10:0] lim;
		reg sh;
		begin
			lim = b[2] ? 11'h77C : b[1] ? 11'h600 : (a[8] && !(a[7] && a[6])) ? 11'h5F2 :
				a[8] ? 11'h600 : 11'h5EE;
			sh = a[2] && (a[1] ^ a[0]);
			exp_dec = {l > lim, !b[3] && k >= 5'h10, a[4] && (b[7] || !a[5]),
				b[4] && sh && !a[1], !b[4] && sh && a[1], c[6] && a[3]};
		end
	endfunction

	task cmp(input [31:0] got, input [31:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask

	// Request held until waitrequest is seen low at a rising edge
	task bus(input w, input [7:0] a, input [31:0] d, input [3:0] e);
		begin
			@(posedge i_clk);
			rd <= !w;
			wr <= w;
			adr <= a;
			wd <= d;
			be <= e;
			n = 0;
			do begin
				@(posedge i_clk);
				n = n + 1;
			end while (wrq !== 1'b0);
			// One wait cycle, then waitrequest low for the completing edge
			cmp(n, 2);
			rdat = rdo;
			rd <= 1'b0;
			wr <= 1'b0;
		end
	endtask

	// Lengths cluster around every limit so each boundary is hit
	task frame;
		reg [10:0] l;
		reg [6:0] e;
		begin
			rnd = nx(rnd);
			case (rnd[5:4])
				2'h0: l = 11'h77C;
				2'h1: l = 11'h600;
				2'h2: l = 11'h5F2;
				default: l = 11'h5EE;
			endcase
			@(posedge i_clk);
			fv <= 1'b1;
			len <= rnd[3] ? rnd[26:16] : l + rnd[7:6] - 11'h1;
			cc <= rnd[31:27];
			fa <= rnd[15:8] ^ {rnd[2:0], rnd[31:26]};
			@(posedge i_clk);
			fv <= 1'b0;
			e = {1'b1, exp_dec(rb, rc, len, cc, fa)};
			#1 cmp({dn, dsz, dco, dvl, dfr, thr, mii}, e);
		end
	endtask

	task setchk;
		cmp({bp, mce, hp, vm, ig, ml}, {rb[5], rb[6], rb[0] ? 6'h30 : 6'h00, rc[7], rc[6],
			rb[2] ? 11'h77C : rb[1] ? 11'h600 : 11'h5EE});
	endtask

	task wrap_up;
		begin
			if (fail_count == 0 && checks > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask

	initial begin
		#1000000;
		fail_count = fail_count + 1;
		wrap_up;
	end

	initial begin
		for (i = 0; i < 2; i = i + 1) begin
			repeat (6) @(posedge i_clk);
			i_rst <= 1'b0;
			rb = {4'hF, s_col, 1'b0, s_max, 1'b0};
			rc = 8'h00;
			bus(1'b0, 8'h10, 32'h0, 4'hF);
			cmp(rdat, {24'h0, rb});
			bus(1'b0, 8'h14, 32'h0, 4'hF);
			cmp(rdat, {24'h0, rc});
			setchk;
			repeat (8) frame;
			if (i == 0) begin
				// Mid-run reset on a clock edge, straps flipped
				@(posedge i_clk);
				s_col <= 1'b0;
				s_max <= 1'b1;
				i_rst <= 1'b1;
			end
		end
		// Lower six bits of C do not exist, a write without byte lane 0 is lost, holes read zero
		bus(1'b1, 8'h14, 32'hFF, 4'hF);
		rc = 8'hC0;
		bus(1'b0, 8'h14, 32'h0, 4'hF);
		cmp(rdat, {24'h0, rc});
		bus(1'b1, 8'h10, 32'h0, 4'hE);
		bus(1'b1, 8'h18, 32'hFF, 4'hF);
		bus(1'b0, 8'h18, 32'h0, 4'hF);
		cmp(rdat, 32'h0);
		bus(1'b0, 8'h10, 32'h0, 4'hF);
		cmp(rdat, {24'h0, rb});
		for (i = 0; i < 40; i = i + 1) begin
			rnd = nx(rnd);
			rb = rnd[7:0];
			bus(1'b1, 8'h10, rnd, 4'h1);
			rnd = nx(rnd);
			rc = {rnd[7:6], 6'h00};
			bus(1'b1, 8'h14, rnd, 4'h1);
			bus(1'b0, 8'h10, 32'h0, 4'hF);
			cmp(rdat, {24'h0, rb});
			setchk;
			repeat (8) frame;
		end
		wrap_up;
	end
endmodule // test_switch_global_control_regs
